// ===== shared/dsh_pkg.sv
package dsh_pkg;
    // Operating modes carried in the first two bits of each header and DAC word; readback words are all zeros
    localparam logic [1:0] MODE_ACQUIRE = 2'h0;
    localparam logic [1:0] MODE_DAC = 2'h1;
    localparam logic [1:0] MODE_ACQ_READ = 2'h2;
    localparam logic [1:0] MODE_READ = 2'h3;
    // Frame lengths in serial clocks
    localparam int ACQ_BITS = 10;
    localparam int DAC_BITS = 24;
    localparam int READ_BITS = 16;
    // Position of the 14 valid readback bits in the 16-bit word
    localparam int READ_LSB = 1;
    localparam int READ_WIDTH = 14;
    // Serial clock divider: half period in system clocks
    localparam logic [3:0] HALF_PERIOD = 4'h8;
    // Gap between frames
    localparam int GAP_NS = 400;
    localparam int CLK_NS = 10;
    localparam int GAP_CYCLES = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] GAP_COUNT = 7'(GAP_CYCLES);
    localparam logic [4:0] BIT_COUNT_RESET = 5'h0;
endpackage : dsh_pkg

// ===== verilog/dsh_sync.sv
`timescale 1ns/1ps
module dsh_sync (
    // Clock
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Data
    input wire logic d_i,
    output logic q_o
);
    import dsh_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
    } dsh_sync_state_t;

    dsh_sync_state_t st;
    dsh_sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign q_o = st.s2;
endmodule : dsh_sync

// ===== verilog/dsh_host.sv
`timescale 1ns/1ps
module dsh_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [1:0] req_mode_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [13:0] req_data_i,
    input wire logic req_read_i,
    // Answer
    output logic rd_valid_o,
    output logic [dsh_pkg::READ_WIDTH-1:0] rd_data_o,
    output logic busy_o,
    // Serial pins
    output logic sclk_o,
    output logic sync_n_o,
    output logic din_o,
    input wire logic dout_i
);
    import dsh_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_HIGH,
        ST_LOW,
        ST_GAP
    } dsh_fsm_t;

    typedef struct packed {
        dsh_fsm_t fsm;
        logic [3:0] div;
        logic [4:0] bits;
        logic [4:0] len;
        logic [23:0] tx;
        logic [15:0] rx;
        logic reading;
        logic [6:0] gap;
        logic sclk;
        logic sync_n;
        logic din;
        logic rd_valid;
        logic [READ_WIDTH-1:0] rd_data;
    } dsh_state_t;

    // Frame select parks high and the clock low out of reset
    localparam dsh_state_t RESET_ST = '{
        fsm: ST_IDLE,
        div: 4'h0,
        bits: BIT_COUNT_RESET,
        len: 5'h0,
        tx: 24'h0,
        rx: 16'h0,
        reading: 1'b0,
        gap: 7'h0,
        sclk: 1'b0,
        sync_n: 1'b1,
        din: 1'b0,
        rd_valid: 1'b0,
        rd_data: '0
    };

    dsh_state_t st;
    dsh_state_t next_st;
    logic dout_s;
    // Decoded request and phase helpers
    logic [4:0] req_len;
    logic [23:0] req_word;
    logic phase_end;
    logic last_bit;

    ////////////////////////////////////////////////////////////////////////////////
    // Readback pin enters through two flops
    dsh_sync u_dout_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(dout_i),
        .q_o(dout_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Request decode: length and left-justified word of the frame asked for
    always_comb begin
        req_len = 5'(ACQ_BITS);
        // Header frames carry only the top ten bits; the rest never leave
        req_word = {req_mode_i, req_addr_i, 14'h0};
        if (req_read_i) begin
            // Readback clocks zeros out; the device ignores its input then
            req_len = 5'(READ_BITS);
            req_word = 24'h0;
        end else if (req_mode_i == MODE_DAC) begin
            // Three bytes back to back inside one frame
            req_len = 5'(DAC_BITS);
            req_word = {req_mode_i, req_addr_i, req_data_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Half period and frame length reached; both read only registered state
    assign phase_end = (st.div == HALF_PERIOD - 4'h1);
    assign last_bit = (st.bits == st.len);

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        // Each serial clock phase lasts HALF_PERIOD system clocks
        case (st.fsm)
            ST_IDLE: begin
                if (req_valid_i) begin
                    next_st.reading = req_read_i;
                    next_st.bits = BIT_COUNT_RESET;
                    next_st.div = 4'h0;
                    // Frame select falls with the take; data follows in setup
                    next_st.sync_n = 1'b0;
                    next_st.len = req_len;
                    next_st.tx = req_word;
                    next_st.fsm = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Data settles one system clock into setup, seven system clocks before the first rising edge
                next_st.div = st.div + 4'h1;
                next_st.din = st.tx[23];
                if (phase_end) begin
                    next_st.div = 4'h0;
                    next_st.sclk = 1'b1;
                    next_st.fsm = ST_HIGH;
                end
            end
            ST_HIGH: begin
                next_st.div = st.div + 4'h1;
                if (st.div == 4'h0) begin
                    // Device shifted on the rising edge; sample after sync delay
                    next_st.rx = st.rx;
                end
                if (phase_end) begin
                    next_st.div = 4'h0;
                    // End of high phase; sampled value has settled past two flops
                    next_st.rx = {st.rx[14:0], dout_s};
                    next_st.sclk = 1'b0;
                    next_st.tx = {st.tx[22:0], 1'b0};
                    next_st.bits = st.bits + 5'h1;
                    next_st.fsm = ST_LOW;
                end
            end
            ST_LOW: begin
                next_st.div = st.div + 4'h1;
                next_st.din = st.tx[23];
                if (phase_end) begin
                    next_st.div = 4'h0;
                    if (last_bit) begin
                        // Last falling edge passed: close half a period later
                        next_st.sync_n = 1'b1;
                        next_st.din = 1'b0;
                        next_st.gap = GAP_COUNT;
                        next_st.fsm = ST_GAP;
                        if (st.reading) begin
                            next_st.rd_data = st.rx[READ_LSB +: READ_WIDTH];
                            next_st.rd_valid = 1'b1;
                        end
                    end else begin
                        next_st.sclk = 1'b1;
                        next_st.fsm = ST_HIGH;
                    end
                end
            end
            ST_GAP: begin
                // Frame select held high for the minimum gap
                next_st.gap = st.gap - 7'h1;
                if (st.gap == 7'h1) begin
                    next_st.fsm = ST_IDLE;
                end
            end
            default: begin
                next_st.fsm = ST_IDLE;
            end
        endcase
    end

    // Clock enable low holds every field, the serial pins included
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= RESET_ST;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ready and busy are combinational so a request is seen at once
    assign req_ready_o = (st.fsm == ST_IDLE);
    assign busy_o = (st.fsm != ST_IDLE);
    // Qualified so a frozen block shows one pulse only
    assign rd_valid_o = st.rd_valid & ce_i;
    assign rd_data_o = st.rd_data;
    assign sclk_o = st.sclk;
    assign sync_n_o = st.sync_n;
    assign din_o = st.din;
endmodule : dsh_host

// ===== tb/dsh_host_properties.sv
`timescale 1ns/1ps
module dsh_host_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic rd_valid_o,
    input wire logic busy_o,
    input wire logic sclk_o,
    input wire logic sync_n_o,
    input wire logic din_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_high8;
        sclk_o [*8];
    endsequence
    a_idle_clk_low: assert property (sync_n_o |-> !sclk_o) else $error("clock outside frame");
    a_take_frame: assert property (req_valid_i && req_ready_o && ce_i |=> !sync_n_o)
        else $error("frame not opened");
    a_frame_hold: assert property ($fell(sync_n_o) |-> !sync_n_o [*8]) else $error("short frame");
    a_gap_wait: assert property ($rose(sync_n_o) |-> !req_ready_o [*8]) else $error("no gap");
    a_half_period: assert property (disable iff (rst_i || !ce_i)
        $rose(sclk_o) |-> s_high8 ##1 !sclk_o)
        else $error("bad clock high phase");
    a_din_steady: assert property (sclk_o |-> $stable(din_o)) else $error("data moved");
    a_rd_pulse: assert property (rd_valid_o |=> !rd_valid_o) else $error("long valid pulse");
    a_busy_ready: assert property (busy_o != req_ready_o) else $error("busy and ready agree");
endmodule : dsh_host_properties
bind dsh_host dsh_host_properties chk_u (.clk_i, .rst_i, .ce_i, .req_valid_i, .req_ready_o,
    .rd_valid_o, .busy_o, .sclk_o, .sync_n_o, .din_o);

// ===== tb/dsh_dev.sv
`timescale 1ns/1ps
module dsh_dev #(parameter logic [13:0] RB = 14'h2a5c) (
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic din_i,
    output logic dout_o = 1'b0
);
    logic [23:0] word = 24'h0;
    int cnt = 0;
    int rcnt = 0;
    logic armed = 1'b0;
    always @(negedge sync_n_i) begin
        cnt = 0;
        rcnt = 0;
        word = 24'h0;
    end
    always @(negedge sclk_i) if (!sync_n_i) begin
        if (armed) rcnt = rcnt + 1;
        else if (cnt < 24) begin
            word = {word[22:0], din_i};
            cnt = cnt + 1;
        end
    end
    // Outside its bits the line shows the inverse, never a held value
    always @(posedge sclk_i) if (!sync_n_i && armed) begin
        dout_o = (rcnt >= 1 && rcnt <= 14) ? RB[14 - rcnt] : ~dout_o;
    end
    always @(posedge sync_n_i) begin
        dout_o = ~dout_o;
        armed = !armed && cnt == 10 && word[9];
    end
endmodule : dsh_dev

// ===== tb/dsh_host_tb.sv
`timescale 1ns/1ps
module dsh_host_tb;
    import dsh_pkg::*;
    localparam logic [13:0] RB_VAL = 14'h2a5c;
    logic clk_i = 0, rst_i = 1, ce_i = 1, req_valid_i = 0, req_read_i = 0;
    logic [1:0] req_mode_i = 2'h0;
    logic [7:0] req_addr_i = 8'h0;
    logic [13:0] req_data_i = 14'h0;
    logic req_ready_o, rd_valid_o, busy_o, sclk_o, sync_n_o, din_o, dout_i;
    logic [13:0] rd_data_o;
    int miscompares = 0, num_checks = 0, rd_seen = 0;
    realtime t_up = 0;
    initial forever #5 clk_i = ~clk_i;
    dsh_host dut_u (.clk_i, .rst_i, .ce_i, .req_valid_i, .req_ready_o, .req_mode_i, .req_addr_i,
        .req_data_i, .req_read_i, .rd_valid_o, .rd_data_o, .busy_o, .sclk_o, .sync_n_o, .din_o,
        .dout_i);
    dsh_dev #(.RB(RB_VAL)) dev_u (.sclk_i(sclk_o), .sync_n_i(sync_n_o), .din_i(din_o),
        .dout_o(dout_i));
    always @(posedge clk_i) if (rd_valid_o === 1'b1) rd_seen++;
    task automatic chk(string what, logic [23:0] exp, logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Inputs change at the falling edge only
    task automatic send(logic [1:0] m, logic [7:0] a, logic [13:0] d, logic rd);
        int n = 0;
        {req_mode_i, req_addr_i, req_data_i, req_read_i, req_valid_i} = {m, a, d, rd, 1'b1};
        while (!req_ready_o && n++ < 200) @(negedge clk_i);
        @(negedge clk_i);
        req_valid_i = 0;
        while (sync_n_o && n++ < 300) @(negedge clk_i);
        chk("frame_open", 24'h0, 24'(sync_n_o));
        if (t_up > 0) chk("gap", 24'h1, 24'($realtime - t_up >= GAP_NS));
        while (!sync_n_o && n++ < 900) @(negedge clk_i);
        chk("frame_end", 24'h1, 24'(sync_n_o));
        t_up = $realtime;
    endtask : send
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            send(2'(m), 8'h5a + 8'(m), 14'h3c96, 1'b0);
            if (m == 1) chk("dac_word", {2'h1, 8'h5b, 14'h3c96}, dev_u.word);
            else chk("hdr_word", {14'h0, 2'(m), 8'h5a + 8'(m)}, dev_u.word);
            chk("bits", (m == 1) ? 24'd24 : 24'd10, 24'(dev_u.cnt));
            if (m > 1) begin
                send(2'h0, 8'h0, 14'h0, 1'b1);
                // The done pulse is counted on the edge after it rises
                @(negedge clk_i);
                chk("rd_clocks", 24'd16, 24'(dev_u.rcnt));
                chk("rd_data", {10'h0, RB_VAL}, {10'h0, rd_data_o});
                chk("rd_pulses", 24'(m - 1), 24'(rd_seen));
            end
        end
        $display("test modes done");
    endtask : t_modes
    // Clock enable dropped in mid-frame: pins freeze, frame still lands whole
    task automatic t_freeze;
        logic [3:0] snap;
        fork
            send(2'h1, 8'h33, 14'h1234, 1'b0);
            begin
                repeat (120) @(negedge clk_i);
                snap = {sclk_o, sync_n_o, din_o, busy_o};
                ce_i = 0;
                repeat (20) @(negedge clk_i);
                chk("frozen", 24'(snap), 24'({sclk_o, sync_n_o, din_o, busy_o}));
                chk("busy", 24'h1, 24'(busy_o));
                ce_i = 1;
            end
        join
        chk("dac_after_hold", {2'h1, 8'h33, 14'h1234}, dev_u.word);
        chk("bits_after_hold", 24'd24, 24'(dev_u.cnt));
        $display("test freeze done");
    endtask : t_freeze
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 0;
        t_modes();
        t_freeze();
        end_sim();
    end
    // Seven frames take about 21 us
    initial begin
        #80us;
        miscompares++;
        end_sim();
    end
endmodule : dsh_host_tb
